// ### rtl/lvs_cfg.svh
// Purpose: Constants of the laser video serializer.
// Assumes: Included by the package and the top module.
// Notes: Definitions only.
`ifndef LVS_CFG_SVH
`define LVS_CFG_SVH
`define LVS_QDEPTH 4
`define LVS_WORD_W 32
`define LVS_BIT_W 5
`define LVS_CNT_W 16
`define LVS_VS_W 13
`define LVS_LEAD_TICKS 6
`define LVS_PLL_RATIO 8
`define LVS_DIV_W 3
`define LVS_LEAD_W 3
`endif

// ### rtl/lvs_pkg.sv
// Purpose: Types of the laser video serializer.
// Assumes: lvs_cfg.svh gives the widths.
// Notes: Nothing here is imported; users write lvs_pkg::name.
`include "lvs_cfg.svh"
package lvs_pkg;
    typedef struct packed {
        logic pll_on;
        logic invert;
        logic reverse;
        logic last_band;
        logic vskip_disable;
        logic [`LVS_VS_W-1:0] top_margin_lines;
        logic [`LVS_CNT_W-1:0] h_margin;
        logic [`LVS_CNT_W-1:0] band_lines;
        logic [`LVS_CNT_W-1:0] line_pixels;
    } lvs_cfg_t;

    typedef enum logic [3:0] {
        LVS_IDLE  = 4'h1,
        LVS_LEAD  = 4'h2,
        LVS_HSKIP = 4'h4,
        LVS_SHIFT = 4'h8
    } lvs_state_t;
endpackage

// ### rtl/lvs_top.sv
// Purpose: Serializes queued 32-bit image words into a laser video stream.
// Assumes: cfg is changed only between pages; engine clock is free running.
// Notes: CPU side on clk, line side on engine_clock_in.
`timescale 1ns/1ps
`default_nettype none
`include "lvs_cfg.svh"
module lvs_top #(
    parameter int DEPTH = `LVS_QDEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic engine_clock_in,
    input wire logic page_sync_in,
    input wire logic line_sync_in,
    input wire lvs_pkg::lvs_cfg_t cfg,
    input wire logic queue_clear,
    input wire logic wr_valid,
    input wire logic [`LVS_WORD_W-1:0] wr_data,
    output logic wr_ready,
    output logic queue_full,
    output logic queue_space_irq,
    output logic page_start_irq,
    output logic band_end_irq,
    output logic line_end_irq,
    output logic serial_video_out
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam int NEV = 3;

    // CPU domain state
    logic [`LVS_WORD_W-1:0] mem [DEPTH];
    logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic [`LVS_WORD_W-1:0] xfer_reg, xfer_next;
    logic ack_tgl_reg, ack_tgl_next;
    logic empty_reg, empty_next;
    logic ready_next, full_next, space_next;
    logic push, pop;
    logic req_s1, req_s2;
    logic [NEV-1:0] ev_s1, ev_s2, ev_s3;

    // Video domain state
    logic rv_s1, rst_v;
    logic pg_s1, pg_s2, pg_s3, ln_s1, ln_s2, ln_s3;
    logic em_s1, em_s2, ak_s1, ak_s2;
    lvs_pkg::lvs_cfg_t cf_s1, cfg_v;
    lvs_pkg::lvs_state_t state_reg, state_next;
    logic [`LVS_DIV_W-1:0] div_reg, div_next;
    logic [`LVS_LEAD_W-1:0] lead_reg, lead_next;
    logic [`LVS_CNT_W-1:0] hcnt_reg, hcnt_next, pix_reg, pix_next;
    logic [`LVS_CNT_W-1:0] band_reg, band_next;
    logic [`LVS_VS_W-1:0] vcnt_reg, vcnt_next;
    logic [`LVS_BIT_W-1:0] bit_reg, bit_next;
    logic [`LVS_WORD_W-1:0] sh_reg, sh_next, nxt_reg, nxt_next, cur;
    logic nv_reg, nv_next, req_tgl_reg, req_tgl_next, ack_prev_reg;
    logic vskip_reg, vskip_next, vis_reg, vis_next;
    logic done_reg, done_next, last_reg, last_next, init_reg;
    logic out_next, tick, page_rise, line_rise, line_fall, capture;
    logic line_end, consume;
    logic [NEV-1:0] ev_tgl_reg, ev_tgl_next;

    // ---------------- CPU domain ----------------
    always_comb begin
        push = wr_valid && wr_ready;
        pop = (req_s2 != ack_tgl_reg) && (count_reg != '0);
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        count_next = count_reg;
        xfer_next = xfer_reg;
        ack_tgl_next = ack_tgl_reg;
        if (queue_clear) begin
            wptr_next = '0;
            rptr_next = '0;
            count_next = '0;
        end else begin
            if (push) begin
                wptr_next = PW'(wptr_reg + 1'b1);
            end
            if (pop) begin
                xfer_next = mem[rptr_reg];
                rptr_next = PW'(rptr_reg + 1'b1);
                ack_tgl_next = ~ack_tgl_reg;
            end
            count_next = CW'(count_reg + CW'(push) - CW'(pop));
        end
        empty_next = (count_next == '0);
        full_next = (count_next == FULL_CNT);
        ready_next = !full_next && !queue_clear;
        space_next = (count_next < FULL_CNT);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= wr_data;
        end
        if (rst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
            xfer_reg <= '0;
            ack_tgl_reg <= 1'b0;
            empty_reg <= 1'b1;
            wr_ready <= 1'b0;
            queue_full <= 1'b0;
            queue_space_irq <= 1'b0;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
            xfer_reg <= xfer_next;
            ack_tgl_reg <= ack_tgl_next;
            empty_reg <= empty_next;
            wr_ready <= ready_next;
            queue_full <= full_next;
            queue_space_irq <= space_next;
            req_s1 <= req_tgl_reg;
            req_s2 <= req_s1;
        end
    end

    // Event toggles from the line side become one-clock pulses
    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi++) begin : g_ev
            always_ff @(posedge clk) begin
                if (rst) begin
                    ev_s1[gi] <= 1'b0;
                    ev_s2[gi] <= 1'b0;
                    ev_s3[gi] <= 1'b0;
                end else begin
                    ev_s1[gi] <= ev_tgl_reg[gi];
                    ev_s2[gi] <= ev_s1[gi];
                    ev_s3[gi] <= ev_s2[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            page_start_irq <= 1'b0;
            band_end_irq <= 1'b0;
            line_end_irq <= 1'b0;
        end else begin
            page_start_irq <= ev_s2[0] ^ ev_s3[0];
            band_end_irq <= ev_s2[1] ^ ev_s3[1];
            line_end_irq <= ev_s2[2] ^ ev_s3[2];
        end
    end

    // ---------------- Video domain ----------------
    always_ff @(posedge engine_clock_in) begin
        rv_s1 <= rst;
        rst_v <= rv_s1;
        pg_s1 <= page_sync_in;
        pg_s2 <= pg_s1;
        pg_s3 <= pg_s2;
        ln_s1 <= line_sync_in;
        ln_s2 <= ln_s1;
        ln_s3 <= ln_s2;
        em_s1 <= empty_reg;
        em_s2 <= em_s1;
        ak_s1 <= ack_tgl_reg;
        ak_s2 <= ak_s1;
        cf_s1 <= cfg;
        cfg_v <= cf_s1;
    end

    always_comb begin
        page_rise = pg_s2 && !pg_s3;
        line_rise = ln_s2 && !ln_s3;
        line_fall = !ln_s2 && ln_s3;
        capture = (ak_s2 != ack_prev_reg);
        // PLL mode: one pixel per eight engine clocks, phase set by line sync
        tick = cfg_v.pll_on ? (div_reg == `LVS_DIV_W'(`LVS_PLL_RATIO - 1))
                            : 1'b1;
        div_next = line_rise ? '0 : `LVS_DIV_W'(div_reg + 1'b1);
        cur = (bit_reg == '0) ? (nv_reg ? nxt_reg : '0) : sh_reg;
        line_end = (pix_reg == `LVS_CNT_W'(cfg_v.line_pixels - 1'b1));
        consume = 1'b0;
        state_next = state_reg;
        lead_next = lead_reg;
        hcnt_next = hcnt_reg;
        pix_next = pix_reg;
        band_next = band_reg;
        vcnt_next = vcnt_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        nxt_next = nxt_reg;
        nv_next = nv_reg;
        req_tgl_next = req_tgl_reg;
        vskip_next = vskip_reg;
        vis_next = vis_reg;
        done_next = done_reg;
        last_next = last_reg;
        ev_tgl_next = ev_tgl_reg;
        out_next = cfg_v.invert;
        if (init_reg) begin
            vcnt_next = cfg_v.top_margin_lines;
        end
        if (page_rise) begin
            vcnt_next = cfg_v.top_margin_lines;
            vskip_next = !cfg_v.vskip_disable;
            band_next = '0;
            done_next = 1'b0;
            last_next = cfg_v.last_band;
            ev_tgl_next[0] = ~ev_tgl_reg[0];
        end
        if (line_rise) begin
            state_next = lvs_pkg::LVS_IDLE;
            hcnt_next = cfg_v.h_margin;
            vis_next = !vskip_reg && !done_reg;
            if (vskip_reg) begin
                if (vcnt_reg == '0) begin
                    vskip_next = 1'b0;
                end else begin
                    vcnt_next = `LVS_VS_W'(vcnt_reg - 1'b1);
                end
            end
        end
        unique case (state_reg)
            lvs_pkg::LVS_IDLE: begin
                if (line_fall && vis_reg) begin
                    state_next = lvs_pkg::LVS_LEAD;
                    lead_next = `LVS_LEAD_W'(`LVS_LEAD_TICKS - 1);
                    pix_next = '0;
                    bit_next = '0;
                end
            end
            lvs_pkg::LVS_LEAD: begin
                if (tick) begin
                    lead_next = `LVS_LEAD_W'(lead_reg - 1'b1);
                    if (lead_reg == '0) begin
                        state_next = (hcnt_reg == '0) ? lvs_pkg::LVS_SHIFT
                                                      : lvs_pkg::LVS_HSKIP;
                    end
                end
            end
            lvs_pkg::LVS_HSKIP: begin
                if (tick) begin
                    hcnt_next = `LVS_CNT_W'(hcnt_reg - 1'b1);
                    if (hcnt_reg == `LVS_CNT_W'(1)) begin
                        state_next = lvs_pkg::LVS_SHIFT;
                    end
                end
            end
            lvs_pkg::LVS_SHIFT: begin
                out_next = serial_video_out;
                if (tick) begin
                    // Normal direction MSB first, reverse LSB first
                    out_next = (cfg_v.reverse ? cur[0] : cur[`LVS_WORD_W-1])
                               ^ cfg_v.invert;
                    sh_next = cfg_v.reverse ? (cur >> 1) : (cur << 1);
                    bit_next = `LVS_BIT_W'(bit_reg + 1'b1);
                    pix_next = `LVS_CNT_W'(pix_reg + 1'b1);
                    if (bit_reg == '0 && nv_reg) begin
                        consume = 1'b1;
                        nv_next = 1'b0;
                        if (em_s2) begin
                            ev_tgl_next[2] = ~ev_tgl_reg[2];
                        end
                    end
                    if (pix_reg == `LVS_CNT_W'(1) &&
                        band_reg == `LVS_CNT_W'(cfg_v.band_lines - 1'b1)) begin
                        ev_tgl_next[1] = ~ev_tgl_reg[1];
                    end
                    if (line_end) begin
                        state_next = lvs_pkg::LVS_IDLE;
                        bit_next = '0;
                        if (band_reg ==
                            `LVS_CNT_W'(cfg_v.band_lines - 1'b1)) begin
                            band_next = '0;
                            done_next = last_reg;
                        end else begin
                            band_next = `LVS_CNT_W'(band_reg + 1'b1);
                        end
                    end
                end
            end
        endcase
        if (capture) begin
            nxt_next = xfer_reg;
            nv_next = 1'b1;
        end else if (!nv_reg && !consume && req_tgl_reg == ak_s2) begin
            req_tgl_next = ~req_tgl_reg;
        end
    end

    always_ff @(posedge engine_clock_in) begin
        if (rst_v) begin
            state_reg <= lvs_pkg::LVS_IDLE;
            div_reg <= '0;
            lead_reg <= '0;
            hcnt_reg <= '0;
            pix_reg <= '0;
            band_reg <= '0;
            vcnt_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '0;
            nxt_reg <= '0;
            nv_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            ack_prev_reg <= 1'b0;
            vskip_reg <= 1'b0;
            vis_reg <= 1'b0;
            done_reg <= 1'b0;
            last_reg <= 1'b0;
            init_reg <= 1'b1;
            ev_tgl_reg <= '0;
            serial_video_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            lead_reg <= lead_next;
            hcnt_reg <= hcnt_next;
            pix_reg <= pix_next;
            band_reg <= band_next;
            vcnt_reg <= vcnt_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            nxt_reg <= nxt_next;
            nv_reg <= nv_next;
            req_tgl_reg <= req_tgl_next;
            ack_prev_reg <= ak_s2;
            vskip_reg <= vskip_next;
            vis_reg <= vis_next;
            done_reg <= done_next;
            last_reg <= last_next;
            init_reg <= 1'b0;
            ev_tgl_reg <= ev_tgl_next;
            serial_video_out <= out_next;
        end
    end

    // Checks
    space_level_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> queue_space_irq == !queue_full)
        else $error("space interrupt disagrees with queue level");
    full_block_a: assert property (@(posedge clk) disable iff (rst)
        queue_full |-> !wr_ready && count_reg == FULL_CNT)
        else $error("full queue still accepts writes");
    clear_empty_a: assert property (@(posedge clk) disable iff (rst)
        queue_clear |=> count_reg == '0 && !wr_ready)
        else $error("queue clear did not empty the queue");
    page_pulse_a: assert property (@(posedge clk) disable iff (rst)
        page_start_irq |=> !page_start_irq)
        else $error("page interrupt longer than one clock");
    band_pulse_a: assert property (@(posedge clk) disable iff (rst)
        band_end_irq |=> !band_end_irq)
        else $error("band interrupt longer than one clock");
    line_pulse_a: assert property (@(posedge clk) disable iff (rst)
        line_end_irq |=> !line_end_irq)
        else $error("line interrupt longer than one clock");
    margin_level_a: assert property (@(posedge engine_clock_in)
        disable iff (rst_v) state_reg != lvs_pkg::LVS_SHIFT
        |=> serial_video_out == $past(cfg_v.invert))
        else $error("margin not at inactive level");
    lead_start_a: assert property (@(posedge engine_clock_in)
        disable iff (rst_v)
        state_reg == lvs_pkg::LVS_IDLE && line_fall && vis_reg && !line_rise
        |=> state_reg == lvs_pkg::LVS_LEAD &&
            lead_reg == `LVS_LEAD_W'(`LVS_LEAD_TICKS - 1))
        else $error("lead count not started at sync release");
    pll_align_a: assert property (@(posedge engine_clock_in)
        disable iff (rst_v) line_rise |=> div_reg == '0)
        else $error("pixel divider not aligned to line sync");
    bypass_tick_a: assert property (@(posedge engine_clock_in)
        disable iff (rst_v) !cfg_v.pll_on |-> tick)
        else $error("bypass mode skipped a pixel");
    line_flush_a: assert property (@(posedge engine_clock_in)
        disable iff (rst_v)
        state_reg == lvs_pkg::LVS_SHIFT && tick && line_end && !line_rise
        |=> bit_reg == '0 && state_reg == lvs_pkg::LVS_IDLE)
        else $error("shift buffer not flushed at line end");
endmodule // lvs_top
`default_nettype wire

// ### bench/lvs_engine_model.sv
// Purpose: Print engine model: makes page and line syncs, reads the video.
// Assumes: engine_clock_in runs free; syncs are active high levels.
// Notes: The bench calls send_page and send_line; results in delay, word.
`timescale 1ns/1ps
`default_nettype none
module lvs_engine_model (
    input wire logic engine_clock_in,
    input wire logic serial_video_out,
    output logic page_sync_in,
    output logic line_sync_in
);
    int delay;
    logic [31:0] word;

    initial begin
        page_sync_in = 1'b0;
        line_sync_in = 1'b0;
        delay = -1;
        word = 32'h0000_0000;
    end

    // Syncs held ten engine clocks, wider than one PLL pixel
    task automatic send_page();
        @(posedge engine_clock_in);
        page_sync_in <= 1'b1;
        repeat (10) @(posedge engine_clock_in);
        page_sync_in <= 1'b0;
        repeat (20) @(posedge engine_clock_in);
    endtask

    // Delay is engine clocks from sync release to the first non-idle bit
    task automatic send_line(input logic idle);
        int n;
        n = 0;
        delay = -1;
        word = 32'h0000_0000;
        @(posedge engine_clock_in);
        line_sync_in <= 1'b1;
        repeat (10) @(posedge engine_clock_in);
        line_sync_in <= 1'b0;
        while (n < 400 && serial_video_out === idle) begin
            @(posedge engine_clock_in);
            n++;
        end
        if (n < 400) begin
            delay = n;
            for (int i = 31; i >= 0; i--) begin
                word[i] = serial_video_out ^ idle;
                @(posedge engine_clock_in);
            end
        end
        // Let the longest line run out before the next sync
        repeat (300) @(posedge engine_clock_in);
    endtask
endmodule // lvs_engine_model
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench of the laser video serializer.
// Assumes: Engine clock 6 ns free running, CPU clock 10 ns.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] k_one = 32'h0000_0001;
    localparam logic [31:0] k_zero = 32'h0000_0000;
    localparam logic [31:0] k_none = 32'hFFFF_FFFF;
    logic clk;
    logic engine_clock_in;
    logic rst;
    lvs_pkg::lvs_cfg_t cfg;
    lvs_pkg::lvs_cfg_t base;
    logic queue_clear;
    logic wr_valid;
    logic [31:0] wr_data;
    logic wr_ready;
    logic queue_full;
    logic queue_space_irq;
    logic page_start_irq;
    logic band_end_irq;
    logic line_end_irq;
    logic serial_video_out;
    logic page_sync_in;
    logic line_sync_in;
    logic [2:0] irq_now;
    logic [2:0] irq_prev = 3'h0;
    int hi[3];
    int rs[3];
    int bad_count;
    int comparisons;
    logic [31:0] w[4] = '{32'h8123_4567, 32'h89AB_CDEF, 32'h8C00_0031,
                          32'hC3C3_3C3C};

    // Video pins wired straight to the port
    lvs_top dut (.clk(clk), .rst(rst), .engine_clock_in(engine_clock_in),
        .page_sync_in(page_sync_in), .line_sync_in(line_sync_in),
        .cfg(cfg), .queue_clear(queue_clear), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .queue_full(queue_full),
        .queue_space_irq(queue_space_irq), .page_start_irq(page_start_irq),
        .band_end_irq(band_end_irq), .line_end_irq(line_end_irq),
        .serial_video_out(serial_video_out));

    lvs_engine_model eng (.engine_clock_in(engine_clock_in),
        .serial_video_out(serial_video_out),
        .page_sync_in(page_sync_in), .line_sync_in(line_sync_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        engine_clock_in = 1'b0;
        #1.7;
        forever #3 engine_clock_in = ~engine_clock_in;
    end

    // Pulse counters: high cycles and rising edges of each event output
    assign irq_now = {line_end_irq, band_end_irq, page_start_irq};
    always @(posedge clk) begin
        irq_prev <= irq_now;
        for (int i = 0; i < 3; i++) begin
            if (irq_now[i] === 1'b1) hi[i]++;
            if (irq_now[i] === 1'b1 && irq_prev[i] !== 1'b1) rs[i]++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Leaves wr_valid high unless last, so bursts run back to back
    task automatic put(input logic [31:0] d, input bit last);
        int n;
        n = 0;
        wr_valid <= 1'b1;
        wr_data <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wr_ready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            give_verdict();
        end
        if (last) wr_valid <= 1'b0;
    endtask

    task automatic page(input lvs_pkg::lvs_cfg_t c);
        int p0;
        cfg <= c;
        repeat (10) @(posedge clk);
        p0 = rs[0];
        eng.send_page();
        repeat (10) @(posedge clk);
        check("page pulse", 32'(rs[0] - p0), k_one);
    endtask

    task automatic run_line(output int d, output logic [31:0] got);
        eng.send_line(cfg.invert);
        d = eng.delay;
        got = eng.word;
        @(posedge clk);
    endtask

    task automatic t_fifo();
        int d;
        int l0;
        int b0;
        logic [31:0] g;
        check("ready", 32'(wr_ready), k_one);
        check("space", 32'(queue_space_irq), k_one);
        page(base);
        // The line side holds one word ahead, so five words fill the queue
        for (int i = 0; i < 5; i++) put(w[i % 4], i == 4);
        repeat (2) @(posedge clk);
        check("full", 32'(queue_full), k_one);
        check("ready full", 32'(wr_ready), k_zero);
        check("space full", 32'(queue_space_irq), k_zero);
        wr_valid <= 1'b1;
        wr_data <= 32'hDEAD_BEEF;
        @(posedge clk);
        wr_valid <= 1'b0;
        l0 = rs[2];
        b0 = rs[1];
        for (int i = 0; i < 5; i++) begin
            run_line(d, g);
            check("word", g, w[i % 4]);
        end
        check("line pulses", 32'(rs[2] - l0), k_one);
        check("band pulses", 32'(rs[1] - b0), 32'h0000_0005);
        check("space drained", 32'(queue_space_irq), k_one);
        put(32'h8888_8888, 1'b0);
        put(32'h9999_9999, 1'b1);
        queue_clear <= 1'b1;
        repeat (3) @(posedge clk);
        check("ready in clear", 32'(wr_ready), k_zero);
        queue_clear <= 1'b0;
        repeat (3) @(posedge clk);
        check("ready after clear", 32'(wr_ready), k_one);
        run_line(d, g);
        check("held word", g, 32'h8888_8888);
        run_line(d, g);
        check("cleared line", 32'(d), k_none);
    endtask

    task automatic t_vskip();
        int d;
        logic [31:0] g;
        lvs_pkg::lvs_cfg_t c;
        c = base;
        c.vskip_disable = 1'b0;
        c.top_margin_lines = 13'h0001;
        page(c);
        for (int i = 0; i < 2; i++) begin
            run_line(d, g);
            check("skipped line", 32'(d), k_none);
        end
        put(w[1], 1'b1);
        run_line(d, g);
        check("first shown", g, w[1]);
    endtask

    task automatic t_hmargin();
        int d0;
        int d4;
        logic [31:0] g;
        lvs_pkg::lvs_cfg_t c;
        c = base;
        page(c);
        put(w[3], 1'b1);
        run_line(d0, g);
        check("lead", 32'(d0 >= 6 && d0 <= 12), k_one);
        c.h_margin = 16'h0004;
        page(c);
        put(w[3], 1'b1);
        run_line(d4, g);
        check("margin", 32'(d4 - d0 >= 3 && d4 - d0 <= 5), k_one);
        check("margin word", g, w[3]);
    endtask

    task automatic t_modes();
        int d;
        logic [31:0] g;
        logic [31:0] e;
        lvs_pkg::lvs_cfg_t c;
        for (int i = 1; i < 4; i++) begin
            c = base;
            c.reverse = i[0];
            c.invert = i[1];
            page(c);
            put(w[2], 1'b1);
            run_line(d, g);
            e = w[2];
            if (i[0]) e = {<<{w[2]}};
            check("idle level", 32'(d >= 6 && d <= 12), k_one);
            check("mode word", g, e);
        end
    endtask

    task automatic t_short();
        int d;
        int l0;
        int b0;
        logic [31:0] g;
        lvs_pkg::lvs_cfg_t c;
        c = base;
        c.line_pixels = 16'h0010;
        c.band_lines = 16'h0002;
        page(c);
        put(w[0], 1'b0);
        put(w[1], 1'b1);
        l0 = rs[2];
        b0 = rs[1];
        run_line(d, g);
        check("short line", g, {w[0][31:16], 16'h0000});
        run_line(d, g);
        check("next word", g, {w[1][31:16], 16'h0000});
        check("line pulse", 32'(rs[2] - l0), k_one);
        check("two line band", 32'(rs[1] - b0), k_one);
    endtask

    task automatic t_pll_final();
        int d;
        int b0;
        logic [31:0] g;
        lvs_pkg::lvs_cfg_t c;
        c = base;
        c.pll_on = 1'b1;
        page(c);
        put(32'h8000_0000, 1'b1);
        run_line(d, g);
        check("pll pixel", g, 32'hFF00_0000);
        c = base;
        c.last_band = 1'b1;
        page(c);
        put(w[3], 1'b0);
        put(w[0], 1'b1);
        b0 = rs[1];
        run_line(d, g);
        check("final band", g, w[3]);
        run_line(d, g);
        check("after final", 32'(d), k_none);
        check("band end", 32'(rs[1] - b0), k_one);
    endtask

    initial begin
        base = '0;
        base.vskip_disable = 1'b1;
        base.band_lines = 16'h0001;
        base.line_pixels = 16'h0020;
        cfg = base;
        rst = 1'b1;
        queue_clear = 1'b0;
        wr_valid = 1'b0;
        wr_data = 32'h0000_0000;
        bad_count = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_fifo();
        t_vskip();
        t_hmargin();
        t_modes();
        t_short();
        t_pll_final();
        for (int i = 0; i < 3; i++) begin
            check("pulse width", 32'(hi[i]), 32'(rs[i]));
        end
        give_verdict();
    end
endmodule // tb
`default_nettype wire
